//--- design/reset_wdt_regs.svh
`ifndef RESET_WDT_REGS_SVH
`define RESET_WDT_REGS_SVH

// ----------------------------------------------------------------
// register addresses on the special function register port
// ----------------------------------------------------------------
`define ADDR_CAUSE      8'hEF
`define ADDR_MODE       8'hD9
`define ADDR_CTRL       8'hD8
`define ADDR_CNT_LO     8'hF9
`define ADDR_CNT_HI     8'hFA
`define ADDR_MOD2_MODE  8'hDC
`define ADDR_OFFSET_LO  8'hFD
`define ADDR_UPDATE_HI  8'hFE

// ----------------------------------------------------------------
// cause flag positions, also the priority order (lowest wins)
// ----------------------------------------------------------------
`define CAUSE_W         7
`define CAUSE_PIN       0
`define CAUSE_PWR       1
`define CAUSE_CLK       2
`define CAUSE_WDT       3
`define CAUSE_SW        4
`define CAUSE_CMP       5
`define CAUSE_MEM       6
`define FLAGS_POWER_ON  7'h02

// ----------------------------------------------------------------
// mode and control fields
// ----------------------------------------------------------------
`define MODE_IDLE_HOLD  7
`define MODE_WDT_EN     6
`define MODE_SEL_HI     3
`define MODE_SEL_LO     1
`define MODE_OVF_IE     0
`define CTRL_RUN        6
`define SEL_DIV12       3'h0
`define SEL_DIV4        3'h1
`define DIV12_LAST      4'hB
`define DIV4_LAST       4'h3
`define DIV1_LAST       4'h0
`define MOD2_SW_TIMER   8'h48
`define UPDATE_HI_RESET 8'hFF
`define OFFSET_RESET    8'hFF

// ----------------------------------------------------------------
// timing and synchroniser layout
// ----------------------------------------------------------------
`define CLK_MHZ         125
`define NS_PER_US       1000
`define RESET_HOLD_NS   100
`define SYNC_W          4
`define SYNC_PIN_N      0
`define SYNC_CMP        1
`define SYNC_CLK_LOST   2
`define SYNC_SUPPLY_LOW 3
`define SYNC_IDLE       4'h3

`endif

//--- design/reset_wdt_pkg.sv
`default_nettype none
`include "reset_wdt_regs.svh"

package reset_wdt_pkg;

	typedef enum logic [1:0]
	{
		ST_RUN  = 2'b01,
		ST_HOLD = 2'b10
	} state_t;

	typedef struct packed
	{
		state_t               st;
		logic [7:0]           hold_cnt;
		logic [`CAUSE_W-1:0]  flags;
		logic                 cmp_en;
		logic                 clk_det_en;
		logic                 supply_en;
		logic                 idle_hold;
		logic                 wdt_en;
		logic [2:0]           clk_sel;
		logic                 ovf_ie;
		logic                 run_bit;
		logic [3:0]           pre;
		logic [15:0]          count;
		logic [7:0]           mod2_mode;
		logic [7:0]           offset;
		logic [7:0]           upd_high;
		logic                 match_prev;
		logic [7:0]           rdata;
		logic                 sys_rst;
	} wd_state_t;

	typedef struct packed
	{
		logic [`SYNC_W-1:0]   s1;
		logic [`SYNC_W-1:0]   s2;
		logic [`SYNC_W-1:0]   s3;
		logic [`SYNC_W-1:0]   level;
	} sync_state_t;

endpackage

`default_nettype wire

//--- design/sync3_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_wdt_regs.svh"

module sync3_filter
(
	input  wire logic                i_clk,
	input  wire logic                i_reset,
	input  wire logic [`SYNC_W-1:0]  i_async,
	output logic      [`SYNC_W-1:0]  o_level
);

	reset_wdt_pkg::sync_state_t s_q;
	reset_wdt_pkg::sync_state_t s_d;

	// a bit changes only once the second and third stages agree
	always_comb
	begin
		s_d       = s_q;
		s_d.s1    = i_async;
		s_d.s2    = s_q.s1;
		s_d.s3    = s_q.s2;
		s_d.level = (~(s_q.s2 ^ s_q.s3) & s_q.s2) | ((s_q.s2 ^ s_q.s3) & s_q.level);
	end

	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			s_q <= '{s1: `SYNC_IDLE, s2: `SYNC_IDLE, s3: `SYNC_IDLE, level: `SYNC_IDLE};
		else
			s_q <= s_d;
	end

	assign o_level = s_q.level;

endmodule // sync3_filter

`default_nettype wire

//--- design/reset_source_and_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_wdt_regs.svh"

// Overview of operation
// (RULE_01) memory error flag reads 1 after a memory error reset; not writable
// (RULE_02) writing 1 arms active-low comparator reset; reads 1 after comparator reset
// (RULE_03) writing 1 forces full system reset; flag then reads 1
// (RULE_04) watchdog flag reads 1 after a watchdog reset; not writable
// (RULE_05) writing 1 arms missing clock detector; reads 1 after its timeout reset
// (RULE_06) writing 1 arms supply monitor; arming while low may reset at once
// (RULE_07) power flag reads 1 after power-on or supply reset; others then meaningless
// (RULE_08) pin flag reads 1 after an external pin reset; not writable
// (RULE_09) software writes whole values to the cause register, never read-modify-write
// (RULE_10) watchdog enable turns compare module two into the watchdog
// (RULE_11) module high byte compares with counter high; low byte holds offset
// (RULE_12) watchdog comes out of every reset enabled
// (RULE_13) watchdog forces the counter to run; run bit writes change nothing
// (RULE_14) run bit reads zero when only the watchdog forces the counter
// (RULE_15) counter byte writes ignored while watchdog enabled
// (RULE_16) clock select and idle hold frozen while watchdog enabled
// (RULE_17) module two held in software timer mode; mode writes ignored
// (RULE_18) update high byte matching counter high byte resets the device
// (RULE_19) any write to update high loads counter high plus offset
// (RULE_20) that sum wraps modulo 256
module reset_source_and_watchdog
(
	input  wire logic        I_CLK,
	input  wire logic        I_RESET,
	input  wire logic [7:0]  I_SFR_ADDR,
	input  wire logic        I_SFR_WR,
	input  wire logic [7:0]  I_SFR_WDATA,
	output logic      [7:0]  O_SFR_RDATA,
	input  wire logic        I_PIN_RESET_N,
	input  wire logic        I_COMPARATOR_OUT,
	input  wire logic        I_CLOCK_MISSING,
	input  wire logic        I_SUPPLY_LOW,
	input  wire logic        I_MEM_ERROR,
	input  wire logic        I_CPU_IDLE,
	output logic             O_SYSTEM_RESET,
	output logic             O_COMPARATOR_RESET_EN,
	output logic             O_MISSING_CLOCK_EN,
	output logic             O_SUPPLY_MONITOR_EN
);

	// ----------------------------------------------------------------
	// constants and helper functions
	// ----------------------------------------------------------------
	localparam int HOLD_CYC = (`RESET_HOLD_NS * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US;
	localparam logic [7:0] HOLD_LAST = 8'(HOLD_CYC - 1);

	// counter array settings as every reset leaves them
	function automatic reset_wdt_pkg::wd_state_t counter_defaults(input reset_wdt_pkg::wd_state_t s);
		reset_wdt_pkg::wd_state_t t;
		t            = s;
		t.st         = reset_wdt_pkg::ST_RUN;
		t.hold_cnt   = 8'h00;
		t.cmp_en     = 1'b0;
		t.clk_det_en = 1'b0;
		t.idle_hold  = 1'b0;
		// (RULE_12) enabled after reset
		t.wdt_en     = 1'b1;
		t.clk_sel    = `SEL_DIV12;
		t.ovf_ie     = 1'b0;
		t.run_bit    = 1'b0;
		t.pre        = 4'h0;
		t.count      = 16'h0000;
		t.mod2_mode  = 8'h00;
		t.offset     = `OFFSET_RESET;
		t.upd_high   = `UPDATE_HI_RESET;
		t.match_prev = 1'b0;
		t.sys_rst    = 1'b0;
		return t;
	endfunction

	function automatic reset_wdt_pkg::wd_state_t power_on_state();
		reset_wdt_pkg::wd_state_t t;
		t           = counter_defaults('0);
		t.flags     = `FLAGS_POWER_ON;
		t.supply_en = 1'b1;
		t.rdata     = 8'h00;
		return t;
	endfunction

	function automatic logic [3:0] prescale_last(input logic [2:0] sel);
		if (sel == `SEL_DIV12)
			return `DIV12_LAST;
		else if (sel == `SEL_DIV4)
			return `DIV4_LAST;
		else
			return `DIV1_LAST;
	endfunction

	localparam reset_wdt_pkg::wd_state_t POR_STATE = power_on_state();

	// ----------------------------------------------------------------
	// state and helper signals
	// ----------------------------------------------------------------
	reset_wdt_pkg::wd_state_t st_q;
	reset_wdt_pkg::wd_state_t st_d;
	logic [`SYNC_W-1:0]       sync_level;
	logic                     pin_low;
	logic                     cmp_low;
	logic                     clk_lost;
	logic                     supply_low;
	logic                     in_run;
	logic                     wr_cause;
	logic                     run_en;
	logic                     tick;
	logic                     match_now;
	logic [7:0]               sum8;
	logic [`CAUSE_W-1:0]      raw_cause;
	logic [`CAUSE_W-1:0]      sel_cause;

	sync3_filter u_sync
	(
		.i_clk   (I_CLK),
		.i_reset (I_RESET),
		.i_async ({I_SUPPLY_LOW, I_CLOCK_MISSING, I_COMPARATOR_OUT, I_PIN_RESET_N}),
		.o_level (sync_level)
	);

	assign pin_low    = ~sync_level[`SYNC_PIN_N];
	assign cmp_low    = ~sync_level[`SYNC_CMP];
	assign clk_lost   = sync_level[`SYNC_CLK_LOST];
	assign supply_low = sync_level[`SYNC_SUPPLY_LOW];
	assign in_run     = (st_q.st == reset_wdt_pkg::ST_RUN);
	assign wr_cause   = I_SFR_WR && (I_SFR_ADDR == `ADDR_CAUSE);

	// (RULE_13) watchdog forces the counter on
	assign run_en     = (st_q.run_bit | st_q.wdt_en) & ~(st_q.idle_hold & I_CPU_IDLE);
	assign tick       = run_en && (st_q.pre >= prescale_last(st_q.clk_sel));
	// (RULE_11) high byte compare
	assign match_now  = st_q.wdt_en && (st_q.count[15:8] == st_q.upd_high);
	// (RULE_20) wraps modulo 256
	assign sum8       = 8'(st_q.count[15:8] + st_q.offset);

	// ----------------------------------------------------------------
	// reset causes, lowest index wins
	// ----------------------------------------------------------------
	always_comb
	begin
		raw_cause             = '0;
		// (RULE_08) pin cause
		raw_cause[`CAUSE_PIN] = pin_low;
		// (RULE_06) supply monitor arm
		raw_cause[`CAUSE_PWR] = supply_low & (st_q.supply_en | (wr_cause & I_SFR_WDATA[`CAUSE_PWR]));
		// (RULE_05) missing clock timeout
		raw_cause[`CAUSE_CLK] = st_q.clk_det_en & clk_lost;
		// (RULE_18) watchdog match
		raw_cause[`CAUSE_WDT] = match_now & ~st_q.match_prev;
		// (RULE_03) software force
		raw_cause[`CAUSE_SW]  = wr_cause & I_SFR_WDATA[`CAUSE_SW];
		// (RULE_02) comparator active low
		raw_cause[`CAUSE_CMP] = st_q.cmp_en & cmp_low;
		raw_cause[`CAUSE_MEM] = I_MEM_ERROR;
		sel_cause             = raw_cause & (~raw_cause + `CAUSE_W'(1));
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		case (st_q.st)
			reset_wdt_pkg::ST_HOLD:
			begin
				if (st_q.hold_cnt != 8'h00)
					st_d.hold_cnt = st_q.hold_cnt - 8'h01;
				else if (!pin_low)
					st_d = counter_defaults(st_q);
			end
			reset_wdt_pkg::ST_RUN:
			begin
				if (tick)
				begin
					st_d.pre   = 4'h0;
					st_d.count = st_q.count + 16'h0001;
				end
				else if (run_en)
					st_d.pre = st_q.pre + 4'h1;
				if (I_SFR_WR)
				begin
					if (I_SFR_ADDR == `ADDR_CAUSE)
					begin
						// (RULE_01) flags not writable
						st_d.cmp_en     = I_SFR_WDATA[`CAUSE_CMP];
						st_d.clk_det_en = I_SFR_WDATA[`CAUSE_CLK];
						st_d.supply_en  = I_SFR_WDATA[`CAUSE_PWR];
					end
					else if (I_SFR_ADDR == `ADDR_MODE)
					begin
						st_d.wdt_en = I_SFR_WDATA[`MODE_WDT_EN];
						st_d.ovf_ie = I_SFR_WDATA[`MODE_OVF_IE];
						// (RULE_16) frozen settings
						if (!st_q.wdt_en)
						begin
							st_d.idle_hold = I_SFR_WDATA[`MODE_IDLE_HOLD];
							st_d.clk_sel   = I_SFR_WDATA[`MODE_SEL_HI:`MODE_SEL_LO];
						end
					end
					else if (I_SFR_ADDR == `ADDR_CTRL)
						st_d.run_bit = I_SFR_WDATA[`CTRL_RUN];
					// (RULE_15) counter writes locked
					else if (I_SFR_ADDR == `ADDR_CNT_LO && !st_q.wdt_en)
						st_d.count[7:0] = I_SFR_WDATA;
					else if (I_SFR_ADDR == `ADDR_CNT_HI && !st_q.wdt_en)
						st_d.count[15:8] = I_SFR_WDATA;
					// (RULE_17) mode writes disabled
					else if (I_SFR_ADDR == `ADDR_MOD2_MODE && !st_q.wdt_en)
						st_d.mod2_mode = I_SFR_WDATA;
					else if (I_SFR_ADDR == `ADDR_OFFSET_LO)
						st_d.offset = I_SFR_WDATA;
					else if (I_SFR_ADDR == `ADDR_UPDATE_HI)
					begin
						// (RULE_19) reload instead of store
						if (st_q.wdt_en)
							st_d.upd_high = sum8;
						else
							st_d.upd_high = I_SFR_WDATA;
					end
				end
				// (RULE_07) a supply cause leaves only the power flag set
				if (|sel_cause)
				begin
					st_d.st       = reset_wdt_pkg::ST_HOLD;
					st_d.hold_cnt = HOLD_LAST;
					st_d.flags    = sel_cause;
				end
			end
			default:
			begin
				st_d.st = reset_wdt_pkg::ST_RUN;
			end
		endcase
		st_d.match_prev = match_now;

		// read data registered one cycle after the address
		st_d.rdata = 8'h00;
		if (I_SFR_ADDR == `ADDR_CAUSE)
			st_d.rdata[`CAUSE_W-1:0] = st_q.flags;
		else if (I_SFR_ADDR == `ADDR_MODE)
		begin
			st_d.rdata[`MODE_IDLE_HOLD]            = st_q.idle_hold;
			st_d.rdata[`MODE_WDT_EN]               = st_q.wdt_en;
			st_d.rdata[`MODE_SEL_HI:`MODE_SEL_LO]  = st_q.clk_sel;
			st_d.rdata[`MODE_OVF_IE]               = st_q.ovf_ie;
		end
		// (RULE_14) software value only
		else if (I_SFR_ADDR == `ADDR_CTRL)
			st_d.rdata[`CTRL_RUN] = st_q.run_bit;
		else if (I_SFR_ADDR == `ADDR_CNT_LO)
			st_d.rdata = st_q.count[7:0];
		else if (I_SFR_ADDR == `ADDR_CNT_HI)
			st_d.rdata = st_q.count[15:8];
		// (RULE_10) module two becomes the watchdog
		else if (I_SFR_ADDR == `ADDR_MOD2_MODE)
			st_d.rdata = st_q.wdt_en ? `MOD2_SW_TIMER : st_q.mod2_mode;
		else if (I_SFR_ADDR == `ADDR_OFFSET_LO)
			st_d.rdata = st_q.offset;
		else if (I_SFR_ADDR == `ADDR_UPDATE_HI)
			st_d.rdata = st_q.upd_high;
		st_d.sys_rst = (st_d.st == reset_wdt_pkg::ST_HOLD);
	end

	always_ff @(posedge I_CLK or posedge I_RESET)
	begin
		if (I_RESET)
			st_q <= POR_STATE;
		else
			st_q <= st_d;
	end

	assign O_SFR_RDATA           = st_q.rdata;
	assign O_SYSTEM_RESET        = st_q.sys_rst;
	assign O_COMPARATOR_RESET_EN = st_q.cmp_en;
	assign O_MISSING_CLOCK_EN    = st_q.clk_det_en;
	assign O_SUPPLY_MONITOR_EN   = st_q.supply_en;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	mem_flag_set_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_01
		(in_run && sel_cause[`CAUSE_MEM]) |=> (st_q.flags == 7'h40) && O_SYSTEM_RESET)
		else $error("memory error reset not recorded");

	cmp_reset_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_02
		(in_run && st_q.cmp_en && cmp_low) |=> O_SYSTEM_RESET)
		else $error("comparator reset missing");

	sw_hold_len_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_03
		(in_run && wr_cause && I_SFR_WDATA[`CAUSE_SW]) |=> O_SYSTEM_RESET [*8])
		else $error("software reset too short");

	wdt_flag_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_04
		(in_run && sel_cause[`CAUSE_WDT]) |=> st_q.flags[`CAUSE_WDT] && !st_q.flags[`CAUSE_PIN])
		else $error("watchdog flag not set");

	pin_flag_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_08
		(in_run && pin_low) |=> st_q.flags == 7'h01)
		else $error("pin flag not set");

	wdt_on_exit_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_12
		$fell(O_SYSTEM_RESET) |-> st_q.wdt_en && st_q.count == 16'h0000)
		else $error("watchdog not enabled after reset");

	forced_count_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_13
		(in_run && st_q.wdt_en && !st_q.run_bit && !(st_q.idle_hold && I_CPU_IDLE) && tick && !(|sel_cause))
		|=> st_q.count == $past(st_q.count) + 16'h0001)
		else $error("counter not forced on");

	run_read_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_14
		(st_q.wdt_en && !st_q.run_bit && I_SFR_ADDR == `ADDR_CTRL) |=> O_SFR_RDATA == 8'h00)
		else $error("run bit reads one");

	count_lock_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_15
		(in_run && st_q.wdt_en && !tick && I_SFR_WR && I_SFR_ADDR == `ADDR_CNT_HI && !(|sel_cause))
		|=> $stable(st_q.count))
		else $error("counter written while locked");

	sel_frozen_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_16
		(in_run && st_q.wdt_en && !(|sel_cause)) |=> $stable(st_q.clk_sel) && $stable(st_q.idle_hold))
		else $error("clock select changed while locked");

	mod2_timer_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_17
		(st_q.wdt_en && I_SFR_ADDR == `ADDR_MOD2_MODE) |=> O_SFR_RDATA == `MOD2_SW_TIMER)
		else $error("module two not in timer mode");

	wdt_fire_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_18
		(in_run && match_now && !st_q.match_prev) |=> O_SYSTEM_RESET)
		else $error("watchdog match did not reset");

	update_load_a: assert property (@(posedge I_CLK) disable iff (I_RESET) // RULE_19
		(in_run && st_q.wdt_en && I_SFR_WR && I_SFR_ADDR == `ADDR_UPDATE_HI && !(|sel_cause))
		|=> st_q.upd_high == 8'($past(st_q.count[15:8]) + $past(st_q.offset)))
		else $error("update byte not reloaded");

endmodule // reset_source_and_watchdog

`default_nettype wire

//--- testbench/tb_reset_source_and_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_wdt_regs.svh"

module tb_reset_source_and_watchdog;

	logic        I_CLK;
	logic        I_RESET;
	logic [7:0]  I_SFR_ADDR;
	logic        I_SFR_WR;
	logic [7:0]  I_SFR_WDATA;
	logic [7:0]  O_SFR_RDATA;
	logic        I_PIN_RESET_N;
	logic        I_COMPARATOR_OUT;
	logic        I_CLOCK_MISSING;
	logic        I_SUPPLY_LOW;
	logic        I_MEM_ERROR;
	logic        I_CPU_IDLE;
	logic        O_SYSTEM_RESET;
	logic        O_COMPARATOR_RESET_EN;
	logic        O_MISSING_CLOCK_EN;
	logic        O_SUPPLY_MONITOR_EN;
	int          error_cnt;
	int          n_compared;

	reset_source_and_watchdog DUT
	(
		.I_CLK                 (I_CLK),
		.I_RESET               (I_RESET),
		.I_SFR_ADDR            (I_SFR_ADDR),
		.I_SFR_WR              (I_SFR_WR),
		.I_SFR_WDATA           (I_SFR_WDATA),
		.O_SFR_RDATA           (O_SFR_RDATA),
		.I_PIN_RESET_N         (I_PIN_RESET_N),
		.I_COMPARATOR_OUT      (I_COMPARATOR_OUT),
		.I_CLOCK_MISSING       (I_CLOCK_MISSING),
		.I_SUPPLY_LOW          (I_SUPPLY_LOW),
		.I_MEM_ERROR           (I_MEM_ERROR),
		.I_CPU_IDLE            (I_CPU_IDLE),
		.O_SYSTEM_RESET        (O_SYSTEM_RESET),
		.O_COMPARATOR_RESET_EN (O_COMPARATOR_RESET_EN),
		.O_MISSING_CLOCK_EN    (O_MISSING_CLOCK_EN),
		.O_SUPPLY_MONITOR_EN   (O_SUPPLY_MONITOR_EN)
	);

	// ----------------------------------------------------------------
	// clock, watchdog and shared tasks
	// ----------------------------------------------------------------
	initial
	begin
		I_CLK = 1'b0;
		forever #4 I_CLK = ~I_CLK;
	end

	initial
	begin
		repeat (80000) @(posedge I_CLK);
		error_cnt++;
		end_of_test();
	end

	// idle level wanders at random; idle hold stays clear so the counter must ignore it
	always @(negedge I_CLK)
		if (!I_RESET)
			I_CPU_IDLE = 1'($urandom % 2);

	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// expected watchdog reload, wrapping in eight bits
	function automatic logic [7:0] reload_exp(input logic [7:0] cnt_hi, input logic [7:0] off);
		return 8'(cnt_hi + off);
	endfunction

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge I_CLK);
		I_SFR_ADDR  = a;
		I_SFR_WDATA = d;
		I_SFR_WR    = 1'b1;
		@(negedge I_CLK);
		I_SFR_WR    = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge I_CLK);
		I_SFR_ADDR = a;
		repeat (2) @(negedge I_CLK);
		d = O_SFR_RDATA;
	endtask

	// waits out a system reset, then checks the cause and the re-armed watchdog
	task automatic wait_rst(input logic [7:0] exp, output int hi);
		int          n;
		logic [7:0]  v;
		n  = 0;
		hi = 0;
		while (O_SYSTEM_RESET !== 1'b1 && n < 40)
		begin
			@(negedge I_CLK);
			n++;
		end
		while (O_SYSTEM_RESET === 1'b1 && hi < 400)
		begin
			@(negedge I_CLK);
			hi++;
		end
		chk("reset_pulse_seen", {7'h00, n < 40 && hi < 400}, 8'h01);
		rd(`ADDR_CAUSE, v);
		chk("cause", v, exp);
		rd(`ADDR_MODE, v);
		chk("mode_after_reset", v, 8'h40);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [7:0]  v;
		logic [7:0]  a;
		logic [7:0]  r;
		logic [7:0]  e;
		int          hi;
		int          n;
		error_cnt = 0;
		n_compared = 0;
		void'($urandom(32'hbe0c6ee5));
		I_RESET = 1'b1;
		I_SFR_ADDR = 8'h00;
		I_SFR_WR = 1'b0;
		I_SFR_WDATA = 8'h00;
		I_PIN_RESET_N = 1'b1;
		I_COMPARATOR_OUT = 1'b1;
		I_CLOCK_MISSING = 1'b0;
		I_SUPPLY_LOW = 1'b0;
		I_MEM_ERROR = 1'b0;
		I_CPU_IDLE = 1'b0;
		repeat (16) @(negedge I_CLK);
		I_RESET = 1'b0;
		rd(`ADDR_CAUSE, v);
		chk("cause_power_on", v, 8'h02);
		rd(`ADDR_MODE, v);
		chk("mode_power_on", v, 8'h40);
		rd(`ADDR_CTRL, v);
		chk("run_bit", {7'h00, v[`CTRL_RUN]}, 8'h00);
		chk("supply_en", {7'h00, O_SUPPLY_MONITOR_EN}, 8'h01);

		// counter forced on at divide-by-12 although the run bit is clear
		wr(`ADDR_CTRL, 8'h00);
		rd(`ADDR_CNT_LO, a);
		repeat (24) @(negedge I_CLK);
		chk("count_advance", O_SFR_RDATA - a, 8'h02);

		// stop the watchdog, preset the counter, arm with a wrapping offset
		wr(`ADDR_MODE, 8'h00);
		wr(`ADDR_MODE, 8'h04);
		wr(`ADDR_CNT_LO, 8'h00);
		wr(`ADDR_CNT_HI, 8'h80);
		rd(`ADDR_CNT_HI, v);
		chk("count_high_free", v, 8'h80);
		r = 8'($urandom_range(8'h81, 8'h90));
		wr(`ADDR_OFFSET_LO, r);
		wr(`ADDR_MODE, 8'h44);
		wr(`ADDR_MODE, 8'hCE);
		rd(`ADDR_MODE, v);
		chk("mode_frozen", v, 8'h44);
		wr(`ADDR_MOD2_MODE, 8'h00);
		rd(`ADDR_MOD2_MODE, v);
		chk("mod2_mode", v, `MOD2_SW_TIMER);
		wr(`ADDR_CNT_HI, 8'h00);
		rd(`ADDR_CNT_HI, v);
		chk("count_high_locked", v, 8'h80);
		wr(`ADDR_UPDATE_HI, 8'($urandom));
		e = reload_exp(8'h80, r);
		rd(`ADDR_UPDATE_HI, v);
		chk("update_high", v, e);
		chk("update_wrapped", {7'h00, v < 8'h80}, 8'h01);
		n = 0;
		while (O_SYSTEM_RESET !== 1'b1 && n < 45000)
		begin
			@(negedge I_CLK);
			n++;
		end
		// counter high steps once per 256 cycles from 0x80 up to the wrapped target
		chk("match_time", {7'h00, n > (int'(e) + 128) * 256 - 320 && n < (int'(e) + 128) * 256 + 8}, 8'h01);
		wait_rst(8'h08, hi);

		// software forced reset and its hold time
		// whole-value writes only
		wr(`ADDR_CAUSE, 8'h12);
		wait_rst(8'h10, hi);
		chk("hold_cycles", 8'(hi), 8'h0D);

		// external pin, then read-only cause bits written with random data
		I_PIN_RESET_N = 1'b0;
		repeat (6) @(negedge I_CLK);
		I_PIN_RESET_N = 1'b1;
		wait_rst(8'h01, hi);
		wr(`ADDR_CAUSE, (8'($urandom) & 8'hC9) | 8'h02);
		repeat (4) @(negedge I_CLK);
		chk("no_reset", {7'h00, O_SYSTEM_RESET}, 8'h00);
		rd(`ADDR_CAUSE, v);
		chk("cause_readonly", v, 8'h01);

		// comparator source
		wr(`ADDR_CAUSE, 8'h22);
		chk("cmp_en", {7'h00, O_COMPARATOR_RESET_EN}, 8'h01);
		I_COMPARATOR_OUT = 1'b0;
		wait_rst(8'h20, hi);
		I_COMPARATOR_OUT = 1'b1;
		chk("cmp_en_cleared", {7'h00, O_COMPARATOR_RESET_EN}, 8'h00);

		// missing clock source
		wr(`ADDR_CAUSE, 8'h06);
		chk("clk_det_en", {7'h00, O_MISSING_CLOCK_EN}, 8'h01);
		I_CLOCK_MISSING = 1'b1;
		wait_rst(8'h04, hi);
		I_CLOCK_MISSING = 1'b0;

		// supply monitor armed while the supply is already low
		wr(`ADDR_CAUSE, 8'h00);
		chk("supply_off", {7'h00, O_SUPPLY_MONITOR_EN}, 8'h00);
		I_SUPPLY_LOW = 1'b1;
		repeat (6) @(negedge I_CLK);
		wr(`ADDR_CAUSE, 8'h02);
		n = 0;
		while (O_SYSTEM_RESET !== 1'b1 && n < 40)
		begin
			@(negedge I_CLK);
			n++;
		end
		I_SUPPLY_LOW = 1'b0;
		wait_rst(8'h02, hi);
		chk("supply_on", {7'h00, O_SUPPLY_MONITOR_EN}, 8'h01);

		// memory error pulse
		@(negedge I_CLK);
		I_MEM_ERROR = 1'b1;
		@(negedge I_CLK);
		I_MEM_ERROR = 1'b0;
		wait_rst(8'h40, hi);
		end_of_test();
	end

endmodule // tb_reset_source_and_watchdog

`default_nettype wire
